// *** src/pfc_defines.vh ***
// Command codes, addresses and timing counts of the flash command sequencer host
`ifndef PFC_DEFINES_VH
`define PFC_DEFINES_VH
// Command unlock addresses and data
`define PFC_ADDR_UNLOCK1 20'h05555
`define PFC_ADDR_UNLOCK2 20'h02AAA
`define PFC_DATA_UNLOCK1 8'hAA
`define PFC_DATA_UNLOCK2 8'h55
`define PFC_CMD_ERASE_SETUP 8'h80
`define PFC_CMD_CHIP_ERASE 8'h10
`define PFC_CMD_PROGRAM 8'hA0
`define PFC_CMD_LOCKOUT 8'h40
`define PFC_CMD_ID_ENTRY 8'h90
`define PFC_CMD_ID_EXIT 8'hF0
// Lock status locations
`define PFC_ADDR_LOCK_BOTTOM 20'h00002
`define PFC_ADDR_LOCK_TOP 20'hF3002
// User operation codes
`define PFC_OP_READ 3'h0
`define PFC_OP_PROGRAM 3'h1
`define PFC_OP_ERASE 3'h2
`define PFC_OP_LOCKOUT 3'h3
`define PFC_OP_ID_ENTRY 3'h4
`define PFC_OP_ID_EXIT 3'h5
`define PFC_OP_LOCK_QUERY 3'h6
// Timing: strobe low width must exceed the 15 ns glitch filter
`define PFC_CLK_NS 8
`define PFC_STROBE_NS 40
`define PFC_STROBE_CYC ((`PFC_STROBE_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`define PFC_SETUP_CYC 2
`define PFC_READ_NS 90
`define PFC_READ_CYC ((`PFC_READ_NS + `PFC_CLK_NS - 1) / `PFC_CLK_NS)
`endif

// *** src/pfc_bus_cycle.v ***
// One timed bus cycle (write or read) on the flash pins
`timescale 1ns/100ps
`include "pfc_defines.vh"
module pfc_bus_cycle (
   // Clock and reset
   input wire mclk_i,
   input wire rst_i,
   // Request
   input wire start_i,
   input wire write_i,
   // Status
   output reg busy_o,
   output reg done_o,
   output reg cs_n_o,
   output reg oe_n_o,
   output reg we_n_o,
   output reg drive_o,
   output reg sample_o
);
   localparam S_IDLE = 2'h0;
   localparam S_SETUP = 2'h1;
   localparam S_STROBE = 2'h2;
   localparam S_HOLD = 2'h3;
   reg [1:0] state;
   reg [7:0] count;

   always @(posedge mclk_i) begin
      done_o <= 1'b0;
      sample_o <= 1'b0;
      if (rst_i) begin
         state <= S_IDLE;
         count <= 8'h00;
         busy_o <= 1'b0;
         cs_n_o <= 1'b1;
         oe_n_o <= 1'b1;
         we_n_o <= 1'b1;
         drive_o <= 1'b0;
      end else begin
         case (state)
            S_IDLE: begin
               if (start_i) begin
                  busy_o <= 1'b1;
                  cs_n_o <= 1'b0;
                  drive_o <= write_i;
                  count <= 8'h00;
                  state <= S_SETUP;
               end
            end
            S_SETUP: begin
               count <= count + 8'h01;
               if (count == `PFC_SETUP_CYC - 1) begin
                  // write strobe only with output enable high
                  we_n_o <= ~write_i;
                  oe_n_o <= write_i;
                  count <= 8'h00;
                  state <= S_STROBE;
               end
            end
            S_STROBE: begin
               count <= count + 8'h01;
               if (count == (write_i ? `PFC_STROBE_CYC : `PFC_READ_CYC) - 1) begin
                  sample_o <= ~write_i;
                  we_n_o <= 1'b1;
                  oe_n_o <= 1'b1;
                  count <= 8'h00;
                  state <= S_HOLD;
               end
            end
            S_HOLD: begin
               // data held past strobe rising edge
               cs_n_o <= 1'b1;
               drive_o <= 1'b0;
               busy_o <= 1'b0;
               done_o <= 1'b1;
               state <= S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end
endmodule

// *** src/pfc_host.v ***
// Host controller that sequences commands to a byte-wide parallel flash
// Overview of operation
// - Byte program is four command writes.
// - Host enables lockout with six prescribed writes.
// - Host exits identification mode after reading lock status.
// - After flash reset, host sets interrupted_o and does not repeat the operation.
// - Chip erase writes AA,55,80,AA,55,10 to fixed addresses.
// - Program writes AA,55,A0 then data to target.
// - Lockout follows erase pattern with 40 last.
// - ID entry ends 90; exit ends F0, always after AA,55.
`timescale 1ns/100ps
`include "pfc_defines.vh"
module pfc_host #(
   parameter TOP_BOOT = 0
) (
   // Clock and reset
   input wire mclk_i,
   input wire rst_i,
   // User command port
   input wire req_i,
   input wire [2:0] op_i,
   input wire [19:0] addr_i,
   input wire [7:0] wdata_i,
   input wire flash_reset_req_i,
   output reg ack_o,
   output reg busy_o,
   output reg [7:0] rdata_o,
   output reg error_o,
   output reg interrupted_o,
   // Flash pins
   output reg [19:0] addr_bus_o,
   input wire [7:0] data_bus_i,
   output reg [7:0] data_bus_o,
   output reg data_bus_oe_o,
   output reg chip_select_n_o,
   output reg output_enable_n_o,
   output reg write_strobe_n_o,
   output reg flash_reset_n_o,
   input wire ready_busy_n_i
);
   localparam ST_IDLE = 3'h0;
   localparam ST_CMD = 3'h1;
   localparam ST_WAITBC = 3'h2;
   localparam ST_POLL = 3'h3;
   localparam ST_READ = 3'h4;
   localparam ST_RESET = 3'h5;

   reg [2:0] state;
   reg [2:0] op;
   reg [2:0] step;
   reg [2:0] nsteps;
   reg [19:0] t_addr;
   reg [7:0] t_data;
   reg [7:0] d_meta, d_sync;
   reg rb_meta, rb_sync;
   reg [7:0] last_read;
   reg have_last;
   reg bc_start, bc_write;
   reg [3:0] rst_cnt;
   wire bc_busy, bc_done, bc_cs_n, bc_oe_n, bc_we_n, bc_drive, bc_sample;

   // Address and data of command write number s for an operation
   function [27:0] cmd_word;
      input [2:0] o;
      input [2:0] s;
      input [19:0] a;
      input [7:0] d;
      begin
         cmd_word = {`PFC_ADDR_UNLOCK1, `PFC_DATA_UNLOCK1};
         if (s == 3'h1 || s == 3'h4)
            cmd_word = {`PFC_ADDR_UNLOCK2, `PFC_DATA_UNLOCK2};
         else if (s == 3'h2) begin
            case (o)
               `PFC_OP_PROGRAM: cmd_word = {`PFC_ADDR_UNLOCK1, `PFC_CMD_PROGRAM};
               `PFC_OP_ID_ENTRY, `PFC_OP_LOCK_QUERY:
                  cmd_word = {`PFC_ADDR_UNLOCK1, `PFC_CMD_ID_ENTRY};
               `PFC_OP_ID_EXIT: cmd_word = {`PFC_ADDR_UNLOCK1, `PFC_CMD_ID_EXIT};
               default: cmd_word = {`PFC_ADDR_UNLOCK1, `PFC_CMD_ERASE_SETUP};
            endcase
         end else if (s == 3'h3 && o == `PFC_OP_PROGRAM)
            cmd_word = {a, d};
         else if (s == 3'h5)
            cmd_word = {`PFC_ADDR_UNLOCK1,
               (o == `PFC_OP_LOCKOUT) ? `PFC_CMD_LOCKOUT : `PFC_CMD_CHIP_ERASE};
      end
   endfunction

   pfc_bus_cycle u_cycle (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .start_i(bc_start),
      .write_i(bc_write),
      .busy_o(bc_busy),
      .done_o(bc_done),
      .cs_n_o(bc_cs_n),
      .oe_n_o(bc_oe_n),
      .we_n_o(bc_we_n),
      .drive_o(bc_drive),
      .sample_o(bc_sample)
   );

   // Pin synchronisers
   always @(posedge mclk_i) begin
      d_meta <= data_bus_i;
      d_sync <= d_meta;
      rb_meta <= ready_busy_n_i;
      rb_sync <= rb_meta;
   end

   // Registered pin outputs
   always @(posedge mclk_i) begin
      if (rst_i) begin
         chip_select_n_o <= 1'b1;
         output_enable_n_o <= 1'b1;
         write_strobe_n_o <= 1'b1;
         data_bus_oe_o <= 1'b0;
      end else begin
         chip_select_n_o <= bc_cs_n;
         output_enable_n_o <= bc_oe_n;
         write_strobe_n_o <= bc_we_n;
         data_bus_oe_o <= bc_drive;
      end
   end

   always @(posedge mclk_i) begin
      ack_o <= 1'b0;
      bc_start <= 1'b0;
      if (rst_i) begin
         state <= ST_IDLE;
         op <= `PFC_OP_READ;
         step <= 3'h0;
         nsteps <= 3'h0;
         t_addr <= 20'h00000;
         t_data <= 8'h00;
         bc_write <= 1'b0;
         busy_o <= 1'b0;
         rdata_o <= 8'h00;
         error_o <= 1'b0;
         interrupted_o <= 1'b0;
         addr_bus_o <= 20'h00000;
         data_bus_o <= 8'h00;
         flash_reset_n_o <= 1'b1;
         last_read <= 8'h00;
         have_last <= 1'b0;
         rst_cnt <= 4'h0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (flash_reset_req_i) begin
                  flash_reset_n_o <= 1'b0;
                  rst_cnt <= 4'h0;
                  busy_o <= 1'b1;
                  state <= ST_RESET;
               end else if (req_i) begin
                  op <= op_i;
                  t_addr <= addr_i;
                  t_data <= wdata_i;
                  busy_o <= 1'b1;
                  error_o <= 1'b0;
                  interrupted_o <= 1'b0;
                  step <= 3'h0;
                  state <= ST_CMD;
                  case (op_i)
                     `PFC_OP_PROGRAM: nsteps <= 3'h4;
                     // six writes for erase and lockout
                     `PFC_OP_ERASE, `PFC_OP_LOCKOUT: nsteps <= 3'h6;
                     // three writes for ID entry and exit
                     `PFC_OP_ID_ENTRY, `PFC_OP_ID_EXIT, `PFC_OP_LOCK_QUERY:
                        nsteps <= 3'h3;
                     default: begin
                        nsteps <= 3'h0;
                        state <= ST_READ;
                     end
                  endcase
               end
            end
            ST_CMD: begin
               {addr_bus_o, data_bus_o} <= cmd_word(op, step, t_addr, t_data);
               bc_write <= 1'b1;
               bc_start <= 1'b1;
               state <= ST_WAITBC;
            end
            ST_WAITBC: begin
               if (bc_done) begin
                  step <= step + 3'h1;
                  if (step != nsteps - 3'h1)
                     state <= ST_CMD;
                  else if (op == `PFC_OP_PROGRAM || op == `PFC_OP_ERASE
                           || op == `PFC_OP_LOCKOUT) begin
                     have_last <= 1'b0;
                     state <= ST_POLL;
                  end else if (op == `PFC_OP_LOCK_QUERY) begin
                     // lock status read in ID mode
                     t_addr <= TOP_BOOT ? `PFC_ADDR_LOCK_TOP : `PFC_ADDR_LOCK_BOTTOM;
                     state <= ST_READ;
                  end else begin
                     busy_o <= 1'b0;
                     ack_o <= 1'b1;
                     state <= ST_IDLE;
                  end
               end
            end
            ST_READ: begin
               // read cycle with write strobe high
               if (!bc_busy && !bc_start && !bc_done) begin
                  addr_bus_o <= t_addr;
                  bc_write <= 1'b0;
                  bc_start <= 1'b1;
               end
               if (bc_sample) begin
                  rdata_o <= d_sync;
                  if (op == `PFC_OP_LOCK_QUERY) begin
                     op <= `PFC_OP_ID_EXIT;
                     nsteps <= 3'h3;
                     step <= 3'h0;
                     state <= ST_CMD;
                  end else begin
                     busy_o <= 1'b0;
                     ack_o <= 1'b1;
                     state <= ST_IDLE;
                  end
               end
            end
            ST_POLL: begin
               // completion when toggle bit stops and ready pin high
               if (!bc_busy && !bc_start && !bc_done) begin
                  addr_bus_o <= t_addr;
                  bc_write <= 1'b0;
                  bc_start <= 1'b1;
               end
               if (bc_sample) begin
                  last_read <= d_sync;
                  have_last <= 1'b1;
                  // ready/busy released and toggle bit 6 unchanged since last read
                  if (have_last && last_read[6] == d_sync[6] && rb_sync) begin
                     rdata_o <= d_sync;
                     // programmed byte differs from the written data in any bit
                     error_o <= (op == `PFC_OP_PROGRAM) && (d_sync != t_data);
                     busy_o <= 1'b0;
                     ack_o <= 1'b1;
                     state <= ST_IDLE;
                  end
               end
            end
            ST_RESET: begin
               rst_cnt <= rst_cnt + 4'h1;
               if (rst_cnt == 4'hF) begin
                  flash_reset_n_o <= 1'b1;
                  interrupted_o <= 1'b1;
                  busy_o <= 1'b0;
                  ack_o <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule

// *** dv/pfc_flash_model.sv ***
// Behavioural byte-wide flash device facing the host
`timescale 1ns/100ps
`include "pfc_defines.vh"
module pfc_flash_model #(
   parameter TOP_BOOT = 0,
   parameter PROG_CYC = 50,
   parameter ERASE_CYC = 300,
   // Identification codes, arbitrary values
   parameter logic [7:0] MFR_ID = 8'hC3,
   parameter logic [7:0] DEV_ID = 8'h5E
) (
   // Flash pins
   input wire [19:0] a_i,
   input wire [7:0] d_i,
   input wire ce_n_i,
   input wire oe_n_i,
   input wire we_n_i,
   input wire rst_n_i,
   // Device outputs
   output wire [7:0] q_o,
   output wire rb_n_o
);
   logic [7:0] mem [int];
   logic [19:0] la, pa;
   logic [7:0] pd, q, lq = 0;
   logic [2:0] st = 0;
   logic idm = 0, lock = 0, tg = 0;
   // high-voltage override level, set from the bench
   logic hv = 0;
   int bc = 0;
   wire drv = !ce_n_i && !oe_n_i && we_n_i && rst_n_i;
   function automatic logic boot(input [19:0] x);
      return TOP_BOOT ? x >= 20'hFC000 : x <= 20'h03FFF;
   endfunction
   function automatic logic [7:0] rd(input [19:0] x);
      return mem.exists(x) ? mem[x] : 8'hFF;
   endfunction
   task automatic wr(input [19:0] x, input [7:0] d);
      logic u1, u2;
      u1 = x == `PFC_ADDR_UNLOCK1;
      u2 = x == `PFC_ADDR_UNLOCK2 && d == `PFC_DATA_UNLOCK2;
      case (st)
         0: begin
            idm = idm && d != `PFC_CMD_ID_EXIT;
            st = (u1 && d == `PFC_DATA_UNLOCK1) ? 3'h1 : 3'h0;
         end
         1, 5: st = u2 ? st + 3'h1 : 3'h0;
         2: begin
            st = 0;
            if (u1 && d == `PFC_CMD_PROGRAM) st = 3;
            if (u1 && d == `PFC_CMD_ERASE_SETUP) st = 4;
            if (u1 && d == `PFC_CMD_ID_ENTRY) idm = 1;
            if (u1 && d == `PFC_CMD_ID_EXIT) idm = 0;
         end
         3: begin
            st = 0;
            if (!(lock && !hv && boot(x))) begin
               mem[x] = rd(x) & d;
               pa = x;
               pd = d;
               bc = PROG_CYC;
            end
         end
         4: st = (u1 && d == `PFC_DATA_UNLOCK1) ? 3'h5 : 3'h0;
         default: begin
            st = 0;
            if (u1 && d == `PFC_CMD_CHIP_ERASE) begin
               foreach (mem[k]) if (!(lock && !hv && boot(k[19:0]))) mem[k] = 8'hFF;
               bc = ERASE_CYC;
            end
            if (u1 && d == `PFC_CMD_LOCKOUT) lock = 1;
         end
      endcase
   endtask
   // Internal timer, no outside clock
   always #8 if (bc > 0) bc--;
   always @(negedge (we_n_i | ce_n_i)) la = a_i;
   always @(posedge (we_n_i | ce_n_i)) begin
      if (oe_n_i && rst_n_i && bc == 0 && !$isunknown({la, d_i})) wr(la, d_i);
   end
   always @(negedge rst_n_i) begin
      bc = 0;
      st = 0;
   end
   always @(negedge oe_n_i) if (!ce_n_i && we_n_i && rst_n_i) begin
      if (bc > 0) tg = ~tg;
      q = rd(a_i);
      if (idm && a_i == (TOP_BOOT ? `PFC_ADDR_LOCK_TOP : `PFC_ADDR_LOCK_BOTTOM)) q = {7'h00, lock};
      // one code table for every entry
      if (idm && a_i == 20'h00000) q = MFR_ID;
      if (idm && a_i == 20'h00001) q = DEV_ID;
      if (bc > 0) q = {a_i == pa ? ~pd[7] : q[7], tg, q[5:0]};
   end
   always @(negedge drv) lq = q;
   assign q_o = drv ? q : ~lq;
   assign rb_n_o = bc == 0;
endmodule

// *** dv/pfc_host_chk.sv ***
// Pin protocol checker for the flash host
`timescale 1ns/100ps
module pfc_host_chk (
   // Clock and reset
   input wire mclk_i,
   input wire rst_i,
   // Flash pins
   input wire [19:0] addr_bus_o,
   input wire [7:0] data_bus_o,
   input wire data_bus_oe_o,
   input wire chip_select_n_o,
   input wire output_enable_n_o,
   input wire write_strobe_n_o,
   input wire flash_reset_n_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   property p_rd_we;
      !output_enable_n_o |-> write_strobe_n_o && !data_bus_oe_o;
   endproperty
   a_rd_we: assert property (p_rd_we) else $error("bus fight on read");
   property p_we_cs;
      !write_strobe_n_o |-> !chip_select_n_o && data_bus_oe_o;
   endproperty
   a_we_cs: assert property (p_we_cs) else $error("write strobe unqualified");
   property p_we_w;
      $fell(write_strobe_n_o) |-> !write_strobe_n_o[*5] ##1 write_strobe_n_o;
   endproperty
   a_we_w: assert property (p_we_w) else $error("write strobe width");
   property p_hold;
      !write_strobe_n_o |=> $stable(addr_bus_o) && $stable(data_bus_o) && !chip_select_n_o;
   endproperty
   a_hold: assert property (p_hold) else $error("write not held");
   property p_rd_w;
      $fell(output_enable_n_o) |-> (!output_enable_n_o && !chip_select_n_o)[*8]
         ##1 !output_enable_n_o[*4];
   endproperty
   a_rd_w: assert property (p_rd_w) else $error("read too short");
   property p_cs_rd;
      $fell(output_enable_n_o) |-> !$past(chip_select_n_o, 2);
   endproperty
   a_cs_rd: assert property (p_cs_rd) else $error("select not ahead of read");
   property p_rst16;
      $fell(flash_reset_n_o) |-> !flash_reset_n_o[*8] ##1 !flash_reset_n_o[*8]
         ##1 flash_reset_n_o;
   endproperty
   a_rst16: assert property (p_rst16) else $error("flash reset width");
   property p_rst_idle;
      !flash_reset_n_o |-> chip_select_n_o && write_strobe_n_o && output_enable_n_o;
   endproperty
   a_rst_idle: assert property (p_rst_idle) else $error("access during reset");
   c_wr: cover property ($fell(write_strobe_n_o));
   c_rd: cover property ($fell(output_enable_n_o));
   c_rst: cover property ($fell(flash_reset_n_o));
endmodule
bind pfc_host pfc_host_chk u_chk (.mclk_i, .rst_i, .addr_bus_o, .data_bus_o, .data_bus_oe_o,
   .chip_select_n_o, .output_enable_n_o, .write_strobe_n_o, .flash_reset_n_o);

// *** dv/parallel_flash_command_sequencer_tb_top.sv ***
// Self-checking bench for the flash command sequencer host
`timescale 1ns/100ps
`include "pfc_defines.vh"
module parallel_flash_command_sequencer_tb_top;
   logic mclk_i = 0, rst_i = 1, req_i = 0, frr = 0;
   logic [2:0] op = 0;
   logic [19:0] ad = 0, a;
   logic [7:0] wd = 0, d, d2;
   logic [31:0] rs = 84485, r;
   logic [9:0] e;
   logic [9:0] exq [$];
   int failures = 0, checks = 0;
   // Identification codes, arbitrary values
   localparam logic [7:0] MFR_ID = 8'hC3;
   localparam logic [7:0] DEV_ID = 8'h5E;
   wire ack, busy, err, intr, doe, cs_n, oe_n, we_n, frst_n, rb_n;
   wire [7:0] rdata, dout, fq, din;
   wire [19:0] fa;
   always #4 mclk_i = ~mclk_i;
   // Data wire from whichever side drives
   assign din = doe ? dout : fq;
   pfc_host DUT (.mclk_i, .rst_i, .req_i, .op_i(op), .addr_i(ad), .wdata_i(wd),
      .flash_reset_req_i(frr), .ack_o(ack), .busy_o(busy), .rdata_o(rdata), .error_o(err),
      .interrupted_o(intr), .addr_bus_o(fa), .data_bus_i(din), .data_bus_o(dout),
      .data_bus_oe_o(doe), .chip_select_n_o(cs_n), .output_enable_n_o(oe_n),
      .write_strobe_n_o(we_n), .flash_reset_n_o(frst_n), .ready_busy_n_i(rb_n));
   pfc_flash_model #(.MFR_ID(MFR_ID), .DEV_ID(DEV_ID)) FM (.a_i(fa), .d_i(din), .ce_n_i(cs_n),
      .oe_n_i(oe_n), .we_n_i(we_n),
      .rst_n_i(frst_n), .q_o(fq), .rb_n_o(rb_n));
   function automatic logic [31:0] xs();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs;
   endfunction
   task automatic print_verdict();
      $display("Comparisons %0d mismatches %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Issue one operation and note its answer {care, error, data}
   task automatic run(input [2:0] o, input [19:0] x, input [7:0] v, input [9:0] ex);
      int n;
      n = 0;
      exq.push_back(ex);
      op = o;
      ad = x;
      wd = v;
      req_i = 1;
      @(posedge mclk_i);
      #1 req_i = 0;
      checks++;
      if (busy !== 1'b1) begin
         failures++;
         $display("CHECK FAILED busy exp 1 seen %b", busy);
      end
      while (ack !== 1'b1 && n < 2000) begin
         @(posedge mclk_i);
         #1 n++;
      end
      if (ack !== 1'b1) begin
         failures++;
         $display("CHECK FAILED ack exp 1 seen %b", ack);
      end
      @(posedge mclk_i);
      #1;
   endtask
   // Compare each answer with the oldest note when that note's care bit is set
   always @(posedge mclk_i) if (ack === 1'b1) begin
      checks++;
      if (exq.size() == 0) begin
         failures++;
         $display("CHECK FAILED answer exp none seen %h", {err, rdata});
      end else begin
         e = exq.pop_front();
         if (e[9] && {err, rdata} !== e[8:0]) begin
            failures++;
            $display("CHECK FAILED answer exp %h seen %h", e[8:0], {err, rdata});
         end
      end
   end
   initial begin
      #200000;
      failures++;
      print_verdict();
   end
   initial begin
      repeat (5) @(posedge mclk_i);
      #1 rst_i = 0;
      run(`PFC_OP_READ, 20'h12345, 8'h00, 10'h2FF);
      d = xs();
      run(`PFC_OP_PROGRAM, 20'h12345, d, {2'b10, d});
      d2 = xs();
      run(`PFC_OP_PROGRAM, 20'h12345, d2, {1'b1, (d & d2) != d2, d & d2});
      run(`PFC_OP_READ, 20'h12345, 8'h00, {2'b10, d & d2});
      run(`PFC_OP_LOCK_QUERY, 20'h00000, 8'h00, 10'h200);
      run(`PFC_OP_PROGRAM, 20'h00010, 8'h5A, 10'h25A);
      run(`PFC_OP_LOCKOUT, 20'h00000, 8'h00, 10'h000);
      run(`PFC_OP_LOCK_QUERY, 20'h00000, 8'h00, 10'h201);
      run(`PFC_OP_PROGRAM, 20'h00020, 8'h00, 10'h3FF);
      run(`PFC_OP_ERASE, 20'h00000, 8'h00, 10'h000);
      run(`PFC_OP_READ, 20'h12345, 8'h00, 10'h2FF);
      run(`PFC_OP_READ, 20'h00010, 8'h00, 10'h25A);
      run(`PFC_OP_ID_ENTRY, 20'h00000, 8'h00, 10'h000);
      run(`PFC_OP_READ, `PFC_ADDR_LOCK_BOTTOM, 8'h00, 10'h201);
      run(`PFC_OP_READ, 20'h00000, 8'h00, {2'b10, MFR_ID});
      run(`PFC_OP_READ, 20'h00001, 8'h00, {2'b10, DEV_ID});
      run(`PFC_OP_ID_EXIT, 20'h00000, 8'h00, 10'h000);
      run(`PFC_OP_READ, `PFC_ADDR_LOCK_BOTTOM, 8'h00, 10'h2FF);
      FM.hv = 1;
      run(`PFC_OP_PROGRAM, 20'h00020, 8'h00, 10'h200);
      FM.hv = 0;
      run(`PFC_OP_PROGRAM, 20'h00030, 8'h00, 10'h3FF);
      repeat (4) begin
         r = xs();
         a = {4'h3, r[15:0]};
         d = r[23:16];
         run(`PFC_OP_PROGRAM, a, d, {2'b10, d});
         run(`PFC_OP_READ, a, 8'h00, {2'b10, d});
      end
      exq.push_back(10'h000);
      frr = 1;
      @(posedge mclk_i);
      #1 frr = 0;
      repeat (24) @(posedge mclk_i);
      #1 checks++;
      if (intr !== 1'b1) begin
         failures++;
         $display("CHECK FAILED interrupted exp 1 seen %b", intr);
      end
      rst_i = 1;
      repeat (2) @(posedge mclk_i);
      #1 rst_i = 0;
      checks++;
      if (busy !== 1'b0 || intr !== 1'b0) begin
         failures++;
         $display("CHECK FAILED idle after reset exp 00 seen %b%b", busy, intr);
      end
      run(`PFC_OP_PROGRAM, 20'h23456, 8'h3C, 10'h23C);
      print_verdict();
   end
endmodule
